// >>> common/hba_pkg.sv
// Shared constants for the host bus agent: register map, fields, states.
// Assumes a 32-bit APB master and the agent core in core/.
`default_nettype none
package hba_pkg;
    localparam int ADDR_HI     = 35;
    localparam int ADDR_LO     = 3;
    localparam int APB_AW      = 12;
    localparam int CFG_W       = 32;
    localparam int CNT_W       = 8;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_ADDRL  = 12'h004;
    localparam logic [11:0] OFF_ADDRH  = 12'h008;
    localparam logic [11:0] OFF_TYPE   = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_CONFIG = 12'h014;
    localparam logic [11:0] OFF_ERRCNT = 12'h018;
    // Control fields
    localparam int CTRL_GO     = 0;
    localparam int CTRL_LOCK   = 1;
    localparam int CTRL_BLOCK  = 2;
    localparam int CTRL_REAL   = 3;
    // Status fields
    localparam int ST_BUSY     = 0;
    localparam int ST_FAST     = 1;
    localparam int ST_AGENT    = 2;
    localparam int ST_RATIO    = 4;
    localparam int ST_AERROBS  = 8;
    localparam int ST_BIDRV    = 9;
    localparam int ST_BIOBS    = 10;
    localparam int ST_PARERR   = 11;
    localparam int ST_ABORT    = 12;
    // Type register fields
    localparam int TYPE_INFO   = 16;
    localparam int INFO_POS    = 8;
    // Power-on configuration bit positions in the latched word (A pin 3 is bit 0)
    localparam int CFG_ADDR_PARITY_ERR_OBS  = 0;
    localparam int CFG_BUS_REINIT_LINE_DRV = 1;
    localparam int CFG_BUS_REINIT_LINE_OBS = 2;
    // Bus rates selected by the speed line
    localparam int BUS_MHZ_SLOW = 66;
    localparam int BUS_MHZ_FAST = 100;
    // Cycles after our strobe in which a parity error aborts our transaction
    localparam logic [1:0] ADDR_PARITY_ERR_WIN  = 2'h3;
    localparam logic       ROT_RESET = 1'b1;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ARB  = 2'b01,
        S_ADDR = 2'b11,
        S_TYPE = 2'b10
    } agent_state_t;
endpackage : hba_pkg
`default_nettype wire

// >>> core/host_bus_agent.sv
// Processor-side host bus agent: address phase, parity, arbitration, reset strapping.
// Assumes bus pins are synchronous to clk and resolved to wire levels outside.
`default_nettype none
// Contract
// - Speed line low means 66 MHz, high 100 MHz; all agents match.
// - Strobe asserted: lines carry address; deasserted: lines carry type info.
// - Upper parity covers address 35:24, lower parity covers 23:3.
// - Parity pin high when an even number of covered lines are low.
// - Parity driven in the same cycle as strobe, address and request type.
// - Address lines sampled at reset release give power-on configuration.
// - Wrap mask asserted in real mode forces address bit 20 to zero.
// - Wrap mask, numeric error and local interrupts latched at release as ratio.
// - Observed strobe starts parity checking and decoding of new transaction.
// - With observation enabled, parity error line aborts the current transaction.
// - Outputs driven and inputs captured on rising bus clock edge.
// - Bus fault line assertions are ignored by the processor.
// - Enabled re-init driver asserts re-init line on an unreliable bus condition.
// - Observed re-init resets state machines, rotating id and counts.
// - Block line asserted means no agent issues new transactions.
// - Priority request stops new requests except an ongoing locked operation.
module host_bus_agent
    import hba_pkg::*;
#(
    parameter bit SUPPORT_FAST = 1'b1
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [hba_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Reset and speed select
    input  wire logic                        busResetN,
    input  wire logic                        speedSelIn,
    output logic                             speedSelOut,
    output logic                             speedSelOe,
    // Address phase
    input  wire logic                        addrStrobeNIn,
    output logic                             addrStrobeNOut,
    output logic                             addrStrobeNOe,
    input  wire logic [hba_pkg::ADDR_HI:3]   addrNIn,
    output logic      [hba_pkg::ADDR_HI:3]   addrNOut,
    output logic                             addrNOe,
    input  wire logic [1:0]                  addrParityBitsIn,
    output logic      [1:0]                  addrParityBitsOut,
    output logic                             addrParityBitsOe,
    output logic      [4:0]                  reqTypeNOut,
    output logic                             requestParityNOut,
    // Error and control lines
    input  wire logic                        addrParityErrNIn,
    output logic                             addrParityErrNOut,
    output logic                             addrParityErrNOe,
    input  wire logic                        busFaultLineN,
    input  wire logic                        busReinitLineNIn,
    output logic                             busReinitLineNOut,
    output logic                             busReinitLineNOe,
    input  wire logic                        blockNextRequestNIn,
    output logic                             blockNextRequestNOut,
    output logic                             blockNextRequestNOe,
    input  wire logic                        priorityRequestN,
    // Arbitration
    input  wire logic                        requestPinFirstNIn,
    output logic                             requestPinFirstNOut,
    output logic                             requestPinFirstNOe,
    input  wire logic                        requestPinSecondN,
    // Reset straps
    input  wire logic                        wrapMaskInN,
    input  wire logic                        ignoreNumericErrorN,
    input  wire logic [1:0]                  localInterruptInputs
);
    import hba_pkg::*;

    agent_state_t           state;
    logic [31:0]            ctrl;
    logic [31:0]            addrLow;
    logic [3:0]             addrHigh;
    logic [31:0]            typeReg;
    logic [CFG_W-1:0]       cfgWord;
    logic [3:0]             ratio;
    logic                   agentId;
    logic                   rotId;
    logic                   resetHeld;
    logic                   pending;
    logic                   lockHeld;
    logic [1:0]             ownWin;
    logic                   parErr;
    logic                   abortFlag;
    logic [CNT_W-1:0]       errCount;
    logic                   aerrDrive;
    logic                   binitDrive;
    logic                   bnrDrive;
    logic                   phase;

    logic                   wrEn;
    logic                   goPulse;
    logic                   resetRelease;
    logic                   busDown;
    logic                   strobeSeen;
    logic                   blockSeen;
    logic                   priSeen;
    logic                   aerrSeen;
    logic                   binitSeen;
    logic                   binitObs;
    logic                   canIssue;
    logic                   grant;
    logic                   otherStrobe;
    logic                   mismatch;
    logic [ADDR_HI:3]       txAddr;
    logic [ADDR_HI:3]       rxAddr;
    logic [1:0]             rxParity;
    logic [31:0]            next_rdata;
    logic                   mapped;

    // Bus-level decodes, every line active low
    assign strobeSeen   = !addrStrobeNIn;
    assign blockSeen    = !blockNextRequestNIn;
    assign priSeen      = !priorityRequestN;
    assign aerrSeen     = !addrParityErrNIn;
    assign binitSeen    = !busReinitLineNIn;
    assign binitObs     = cfgWord[CFG_BUS_REINIT_LINE_OBS];
    assign resetRelease = resetHeld && busResetN;
    assign busDown      = sys_rst || !busResetN || (binitSeen && binitObs);
    assign wrEn         = psel && penable && pwrite;
    assign goPulse      = wrEn && (paddr == OFF_CTRL) && pwdata[CTRL_GO];

    // Address with wrap masking applied before it reaches the bus
    always_comb begin
        txAddr = {addrHigh, addrLow[31:3]};
        if (!wrapMaskInN && ctrl[CTRL_REAL]) begin
            txAddr[20] = 1'b0;
        end
    end

    // Observed address parity check for other agents' strobes
    assign rxAddr      = ~addrNIn;
    assign rxParity    = {~^rxAddr[ADDR_HI:24], ~^rxAddr[23:3]};
    assign otherStrobe = strobeSeen && (state != S_ADDR);
    assign mismatch    = otherStrobe && (rxParity != addrParityBitsIn);

    // Issue gating and symmetric arbitration
    assign canIssue = !blockSeen && (!priSeen || (typeReg[CTRL_LOCK] && lockHeld));
    assign grant    = requestPinSecondN || (rotId != agentId);

    // Reset strapping on the release of bus reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resetHeld <= 1'b0;
            cfgWord   <= '0;
            ratio     <= 4'h0;
            agentId   <= 1'b0;
        end else begin
            resetHeld <= !busResetN;
            if (resetRelease) begin
                cfgWord <= ~addrNIn[CFG_W+2:3];
                ratio   <= {!wrapMaskInN, !ignoreNumericErrorN, localInterruptInputs};
                agentId <= requestPinFirstNIn && !requestPinSecondN;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl     <= CTRL_RST;
            addrLow  <= '0;
            addrHigh <= 4'h0;
            typeReg  <= '0;
        end else if (wrEn) begin
            case (paddr)
                OFF_CTRL:  ctrl     <= {pwdata[31:1], 1'b0};
                OFF_ADDRL: addrLow  <= pwdata;
                OFF_ADDRH: addrHigh <= pwdata[3:0];
                OFF_TYPE:  typeReg  <= pwdata;
                default:   ctrl     <= ctrl;
            endcase
        end
    end

    // Transaction state machine, all on the rising edge
    always_ff @(posedge clk) begin
        if (busDown) begin
            state    <= S_IDLE;
            pending  <= 1'b0;
            lockHeld <= 1'b0;
        end else begin
            if (goPulse) begin
                pending <= 1'b1;
            end
            case (state)
                S_IDLE: begin
                    if (pending) begin
                        state <= S_ARB;
                    end
                end
                S_ARB: begin
                    if (grant && canIssue && !strobeSeen) begin
                        state <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    state    <= S_TYPE;
                    lockHeld <= typeReg[CTRL_LOCK];
                end
                S_TYPE: begin
                    state   <= S_IDLE;
                    pending <= goPulse;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Rotating owner id tracks the last agent to issue
    always_ff @(posedge clk) begin
        if (busDown) begin
            rotId <= ROT_RESET;
        end else if (state == S_ADDR) begin
            rotId <= agentId;
        end else if (otherStrobe) begin
            rotId <= !agentId;
        end
    end

    // Parity error handling and abort of our own transaction
    always_ff @(posedge clk) begin
        if (busDown) begin
            ownWin    <= 2'h0;
            errCount  <= '0;
            aerrDrive <= 1'b0;
            parErr    <= 1'b0;
            abortFlag <= 1'b0;
        end else begin
            aerrDrive <= mismatch;
            if (mismatch) begin
                errCount <= errCount + 1'b1;
            end
            if (state == S_ADDR) begin
                ownWin <= ADDR_PARITY_ERR_WIN;
            end else if (aerrSeen && cfgWord[CFG_ADDR_PARITY_ERR_OBS]) begin
                ownWin <= 2'h0;
            end else if (ownWin != 2'h0) begin
                ownWin <= ownWin - 1'b1;
            end
            if (mismatch) begin
                parErr <= 1'b1;
            end else if (wrEn && paddr == OFF_STATUS && pwdata[ST_PARERR]) begin
                parErr <= 1'b0;
            end
            if (aerrSeen && cfgWord[CFG_ADDR_PARITY_ERR_OBS] && ownWin != 2'h0) begin
                abortFlag <= 1'b1;
            end else if (wrEn && paddr == OFF_STATUS && pwdata[ST_ABORT]) begin
                abortFlag <= 1'b0;
            end
        end
    end

    // Re-init driver fires when another strobe lands in our type cycle
    always_ff @(posedge clk) begin
        if (sys_rst || !busResetN) begin
            binitDrive <= 1'b0;
        end else begin
            binitDrive <= cfgWord[CFG_BUS_REINIT_LINE_DRV] && (state == S_TYPE) && strobeSeen;
        end
    end

    // Block line only changes on even phases to avoid wire-OR glitches
    always_ff @(posedge clk) begin
        if (sys_rst || !busResetN) begin
            phase    <= 1'b0;
            bnrDrive <= 1'b0;
        end else begin
            phase <= !phase;
            if (!phase) begin
                bnrDrive <= ctrl[CTRL_BLOCK];
            end
        end
    end

    // APB read data captured in the setup cycle
    always_comb begin
        next_rdata = 32'h0000_0000;
        mapped     = 1'b1;
        case (paddr)
            OFF_CTRL:   next_rdata = ctrl;
            OFF_ADDRL:  next_rdata = addrLow;
            OFF_ADDRH:  next_rdata = {28'h000_0000, addrHigh};
            OFF_TYPE:   next_rdata = typeReg;
            OFF_STATUS: begin
                next_rdata[ST_BUSY]            = pending;
                next_rdata[ST_FAST]            = speedSelIn;
                next_rdata[ST_AGENT]           = agentId;
                next_rdata[ST_RATIO+3:ST_RATIO] = ratio;
                next_rdata[ST_AERROBS]         = cfgWord[CFG_ADDR_PARITY_ERR_OBS];
                next_rdata[ST_BIDRV]           = cfgWord[CFG_BUS_REINIT_LINE_DRV];
                next_rdata[ST_BIOBS]           = binitObs;
                next_rdata[ST_PARERR]          = parErr;
                next_rdata[ST_ABORT]           = abortFlag;
            end
            OFF_CONFIG: next_rdata = cfgWord;
            OFF_ERRCNT: next_rdata = {{(32-CNT_W){1'b0}}, errCount};
            default:    mapped     = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= !mapped;
        end
    end
    assign pready = 1'b1;

    // Pin drivers; the bus fault line is deliberately never read
    assign speedSelOut       = 1'b0;
    assign speedSelOe        = !SUPPORT_FAST;
    assign addrStrobeNOut    = 1'b0;
    assign addrStrobeNOe     = (state == S_ADDR);
    assign addrNOe           = (state == S_ADDR) || (state == S_TYPE);
    assign addrParityBitsOe  = (state == S_ADDR);
    assign addrParityBitsOut = {~^txAddr[ADDR_HI:24], ~^txAddr[23:3]};
    assign reqTypeNOut       = ~typeReg[4:0];
    assign requestParityNOut = ~^typeReg[4:0];
    assign addrParityErrNOut = 1'b0;
    assign addrParityErrNOe  = aerrDrive;
    assign busReinitLineNOut = 1'b0;
    assign busReinitLineNOe  = binitDrive;
    assign blockNextRequestNOut = 1'b0;
    assign blockNextRequestNOe  = bnrDrive;
    assign requestPinFirstNOut  = 1'b0;
    assign requestPinFirstNOe   = busResetN && (state == S_ARB);

    always_comb begin
        addrNOut = ~txAddr;
        if (state == S_TYPE) begin
            addrNOut = '1;
            addrNOut[INFO_POS+15:INFO_POS] = ~typeReg[TYPE_INFO+15:TYPE_INFO];
        end
    end

    // Checks
    sequence s_addrPhase;
        addrStrobeNOe && !addrStrobeNOut;
    endsequence
    sequence s_typePhase;
        !addrStrobeNOe && addrNOe && addrNOut[23:8] == ~typeReg[31:16];
    endsequence

    property p_parity;
        @(posedge clk) disable iff (sys_rst)
        s_addrPhase |-> addrParityBitsOe &&
            addrParityBitsOut == {~^(~addrNOut[ADDR_HI:24]), ~^(~addrNOut[23:3])};
    endproperty
    a_parity: assert property (p_parity) else $error("address parity wrong");

    property p_phases;
        @(posedge clk) disable iff (sys_rst || busDown)
        s_addrPhase |=> s_typePhase;
    endproperty
    a_phases: assert property (p_phases) else $error("type phase missing");

    property p_mask;
        @(posedge clk) disable iff (sys_rst)
        (s_addrPhase and (!wrapMaskInN && ctrl[CTRL_REAL])) |-> addrNOut[20];
    endproperty
    a_mask: assert property (p_mask) else $error("bit 20 not masked");

    property p_block;
        @(posedge clk) disable iff (sys_rst)
        state == S_ARB && blockSeen |=> state != S_ADDR;
    endproperty
    a_block: assert property (p_block) else $error("issued while blocked");

    property p_prio;
        @(posedge clk) disable iff (sys_rst)
        state == S_ARB && priSeen && !(typeReg[CTRL_LOCK] && lockHeld) |=> state != S_ADDR;
    endproperty
    a_prio: assert property (p_prio) else $error("issued under priority");

    property p_reinit;
        @(posedge clk) disable iff (sys_rst)
        binitSeen && binitObs |=> state == S_IDLE && errCount == 0 && rotId == ROT_RESET;
    endproperty
    a_reinit: assert property (p_reinit) else $error("re-init not applied");

    property p_bnrEdge;
        @(posedge clk) disable iff (sys_rst)
        $changed(bnrDrive) && $past(busResetN) |-> $past(phase) == 1'b0;
    endproperty
    a_bnrEdge: assert property (p_bnrEdge) else $error("block line moved off edge");

    property p_strap;
        @(posedge clk) disable iff (sys_rst)
        resetRelease |=> cfgWord == ~$past(addrNIn[CFG_W+2:3]) &&
            agentId == ($past(requestPinFirstNIn) && !$past(requestPinSecondN)) &&
            ratio == {!$past(wrapMaskInN), !$past(ignoreNumericErrorN), $past(localInterruptInputs)};
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");

    property p_abort;
        @(posedge clk) disable iff (sys_rst)
        s_addrPhase ##1 (aerrSeen && cfgWord[CFG_ADDR_PARITY_ERR_OBS] && !busDown)[*1] |=> abortFlag;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not flagged");

    property p_check;
        @(posedge clk) disable iff (sys_rst)
        mismatch && !busDown |=> parErr && addrParityErrNOe ##1 !addrParityErrNOe || mismatch;
    endproperty
    a_check: assert property (p_check) else $error("parity error not reported");

    property p_reinitDrv;
        @(posedge clk) disable iff (sys_rst)
        busResetN && cfgWord[CFG_BUS_REINIT_LINE_DRV] && state == S_TYPE && strobeSeen |=> busReinitLineNOe;
    endproperty
    a_reinitDrv: assert property (p_reinitDrv) else $error("re-init not driven");
endmodule : host_bus_agent
`default_nettype wire

// >>> tb/far_agent.sv
// Far-side model: chipset and second bus agent driving the shared lines.
// Assumes the bench resolves wire levels and calls issue from its own thread.
`default_nettype none
module far_agent (
    // Bus clock
    input wire logic clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released lines read high through termination, except pBr0N, which starts low for the reset strap
    logic        pStrobeN = 1'b1;
    logic [35:3] pAddrN   = '1;
    logic [1:0]  pParN    = 2'b11;
    logic        pAerrN   = 1'b1;
    logic        pReinitN = 1'b1;
    logic        pBlockN  = 1'b1;
    logic        pPrioN   = 1'b1;
    logic        pReqN    = 1'b1;
    logic        pBr0N    = 1'b0;
    logic        pFaultN  = 1'b1;
    // One request cycle, then lines released
    task automatic issue(input logic [35:3] a, input logic bad);
        @(posedge clk);
        pStrobeN <= 1'b0;
        pAddrN   <= ~a;
        pParN    <= {~^a[35:24], ~^a[23:3] ^ bad};
        @(posedge clk);
        pStrobeN <= 1'b1;
        pAddrN   <= '1;
        pParN    <= 2'b11;
    endtask : issue
endmodule : far_agent
`default_nettype wire

// >>> tb/host_bus_agent_signalling_tb_top.sv
// Bench for the host bus agent: APB stimulus, far-side model, behavioural checks.
// Assumes hba_pkg, host_bus_agent and far_agent are compiled first.
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module host_bus_agent_signalling_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hba_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic busResetN = 1'b0, wrapMaskInN, ignoreNumericErrorN;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, t;
    logic [1:0] localInterruptInputs, addrParityBitsIn, addrParityBitsOut;
    logic pready, pslverr, speedSelIn, speedSelOut, speedSelOe, addrStrobeNIn, addrStrobeNOut;
    logic addrStrobeNOe, addrNOe, addrParityBitsOe, requestParityNOut, addrParityErrNIn;
    logic addrParityErrNOut, addrParityErrNOe, busFaultLineN, busReinitLineNIn;
    logic busReinitLineNOut, busReinitLineNOe, blockNextRequestNIn, blockNextRequestNOut;
    logic blockNextRequestNOe, priorityRequestN, requestPinFirstNIn, requestPinFirstNOut;
    logic requestPinFirstNOe, requestPinSecondN;
    logic [35:3] addrNIn, addrNOut, strap;
    logic [4:0] reqTypeNOut;
    logic [35:0] addr;
    logic [3:0] s4;
    int miscompares = 0, comparisons = 0, cycles = 0;
    always #2.5 clk = ~clk;
    far_agent i_far_agent (.clk(clk));
    host_bus_agent i_host_bus_agent (.*);
    // Shared lines: low if any party pulls, else pulled up
    assign speedSelIn = ~(speedSelOe & ~speedSelOut);
    assign addrStrobeNIn = i_far_agent.pStrobeN & ~(addrStrobeNOe & ~addrStrobeNOut);
    assign addrNIn = i_far_agent.pAddrN & (addrNOe ? addrNOut : '1);
    assign addrParityBitsIn = i_far_agent.pParN & (addrParityBitsOe ? addrParityBitsOut : 2'b11);
    assign addrParityErrNIn = i_far_agent.pAerrN & ~(addrParityErrNOe & ~addrParityErrNOut);
    assign busReinitLineNIn = i_far_agent.pReinitN & ~(busReinitLineNOe & ~busReinitLineNOut);
    assign blockNextRequestNIn = i_far_agent.pBlockN & ~(blockNextRequestNOe & ~blockNextRequestNOut);
    assign requestPinFirstNIn = i_far_agent.pBr0N & ~(requestPinFirstNOe & ~requestPinFirstNOut);
    assign busFaultLineN = i_far_agent.pFaultN;
    assign priorityRequestN = i_far_agent.pPrioN;
    assign requestPinSecondN = i_far_agent.pReqN;
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_strobe();
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            #1;
            if (addrStrobeNIn === 1'b0) return;
        end
        `CHK(addrStrobeNIn, 1'b0)
    endtask : wait_strobe
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        void'($urandom(11));
        s4 = 4'($urandom);
        strap = 33'({$urandom, $urandom}) & ~33'h0_0000_0007;
        i_far_agent.pAddrN = strap;
        {wrapMaskInN, ignoreNumericErrorN, localInterruptInputs} = s4;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        busResetN <= 1'b1;
        repeat (2) @(posedge clk);
        i_far_agent.pAddrN <= '1;
        i_far_agent.pBr0N <= 1'b1;
        {wrapMaskInN, ignoreNumericErrorN, localInterruptInputs} <= 4'b1100;
        apb(1'b0, OFF_CONFIG, '0);
        `CHK(r, ~strap[34:3])
        apb(1'b0, OFF_STATUS, '0);
        `CHK({r[10:4], r[2:1]}, {3'b111, ~s4[3:2], s4[1:0], 2'b01})
        for (int i = 0; i < 4; i++) begin
            addr = (36'({$urandom, $urandom}) | 36'h0_0010_0000) & ~36'h0_0000_0007;
            t = $urandom & 32'hFFFF_001D;
            wrapMaskInN <= (i != 3);
            i_far_agent.pPrioN <= (i != 1);
            i_far_agent.pBlockN <= (i != 2);
            apb(1'b1, OFF_ADDRL, addr[31:0]);
            apb(1'b1, OFF_ADDRH, {28'h000_0000, addr[35:32]});
            apb(1'b1, OFF_TYPE, t);
            apb(1'b1, OFF_CTRL, {28'h000_0000, i > 0, 3'b001});
            if (i == 1 || i == 2) begin
                repeat (10) begin
                    @(posedge clk);
                    #1;
                    `CHK(addrStrobeNIn, 1'b1)
                end
                i_far_agent.pPrioN <= 1'b1;
                i_far_agent.pBlockN <= 1'b1;
            end
            wait_strobe();
            if (i == 3) addr[20] = 1'b0;
            `CHK(addrNIn, ~addr[35:3])
            `CHK(addrParityBitsIn, {~1'($countones(addr[35:24])), ~1'($countones(addr[23:3]))})
            `CHK({reqTypeNOut, requestParityNOut}, {~t[4:0], ~^t[4:0]})
            @(posedge clk);
            if (i == 3) i_far_agent.pAerrN <= 1'b0;
            #1;
            `CHK({addrStrobeNIn, addrNIn[35:24], addrNIn[7:3]}, 18'h3_FFFF)
            @(posedge clk);
            i_far_agent.pAerrN <= 1'b1;
        end
        apb(1'b0, OFF_STATUS, '0);
        `CHK({r[12], r[0]}, 2'b10)
        apb(1'b1, OFF_CTRL, 32'h0000_0004);
        repeat (3) @(posedge clk);
        #1;
        `CHK(blockNextRequestNOe, 1'b1)
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        apb(1'b0, 12'h01C, '0);
        `CHK(pslverr, 1'b1)
        i_far_agent.issue(addr[35:3], 1'b1);
        #1;
        `CHK(addrParityErrNOe, 1'b1)
        @(posedge clk);
        #1;
        `CHK(addrParityErrNOe, 1'b0)
        i_far_agent.pFaultN <= 1'b0;
        apb(1'b0, OFF_ERRCNT, '0);
        `CHK(r[7:0], 8'h01)
        i_far_agent.pFaultN <= 1'b1;
        i_far_agent.pReinitN <= 1'b0;
        @(posedge clk);
        i_far_agent.pReinitN <= 1'b1;
        apb(1'b0, OFF_STATUS, '0);
        `CHK(r[12:11], 2'b00)
        apb(1'b0, OFF_ERRCNT, '0);
        `CHK(r[7:0], 8'h00)
        final_report();
    end
endmodule : host_bus_agent_signalling_tb_top
`default_nettype wire
